/* rtl/bpbs_port.v */
/*
 * Eight-pin shared bidirectional port with APB registers.
 * Assumes pins are synchronous to clk and the board resolves pin levels.
 */
`timescale 1ns/1ns
`include "bpbs_regs.vh"
module bpbs_port #(
	// One on the larger package variant with the memory bus.
	parameter HAS_MEM_BUS = 1
) (
	// Clock and reset.
	input wire clk,
	input wire reset,
	// APB slave.
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output wire pready,
	output wire pslverr,
	output reg [31:0] prdata,
	// Port pins.
	input wire [7:0] pinIn,
	output wire [7:0] pinOut,
	output wire [7:0] pinOe,
	// Memory bus low address/data byte.
	input wire [7:0] lowAddrDataOut,
	input wire lowAddrDataOe,
	output wire [7:0] lowAddrDataIn,
	// Slave port strobes from the neighbouring port.
	input wire slaveRead_n,
	input wire slaveWrite_n,
	input wire slaveSelect_n,
	// Slave port status.
	output reg [7:0] slaveWriteData,
	output reg slaveWriteFull,
	output wire slavePortActive
);
	// Register storage.
	reg [7:0] outputLatch;
	reg [7:0] directionControl;
	reg [7:0] memoryControl;
	reg [7:0] slaveControl;
	// Decoded access signals.
	wire access;
	wire wrEn;
	wire hitPin;
	wire hitLatch;
	wire hitDir;
	wire hitMem;
	wire hitSlave;
	wire mapped;
	// Ownership of the pins.
	wire extBusDisable;
	wire memBusActive;
	wire slaveMode;
	wire slaveReadDrive;
	wire slaveCapture;
	// Read multiplexer output.
	reg [31:0] next_prdata;

	// Every access completes in its first access cycle.
	assign pready = 1'b1;
	assign access = psel & penable;
	assign wrEn = access & pwrite;
	assign hitPin = paddr == `BPBS_OFF_PIN_VALUE;
	assign hitLatch = paddr == `BPBS_OFF_OUTPUT_LATCH;
	assign hitDir = paddr == `BPBS_OFF_DIRECTION;
	assign hitMem = paddr == `BPBS_OFF_MEM_CTRL;
	assign hitSlave = paddr == `BPBS_OFF_SLAVE_CTRL;
	assign mapped = hitPin | hitLatch | hitDir | hitMem | hitSlave;
	// Unmapped addresses answer with an error and read zero.
	assign pslverr = access & ~mapped;

	// The memory bus exists only on the larger variant.
	assign extBusDisable = memoryControl[`BPBS_EXT_BUS_DISABLE_BIT];
	assign memBusActive = (HAS_MEM_BUS != 0) & ~extBusDisable;
	// Slave mode works only while the memory bus has let go.
	assign slaveMode = slaveControl[`BPBS_SLAVE_PORT_MODE_BIT];
	assign slavePortActive = slaveMode & ~memBusActive;
	assign lowAddrDataIn = pinIn;

	// Register writes; both data addresses reach the same latch.
	always @(posedge clk) begin
		if (reset) begin
			outputLatch <= `BPBS_RST_LATCH;
			directionControl <= `BPBS_RST_DIRECTION;
			memoryControl <= `BPBS_RST_MEM_CTRL;
			slaveControl <= `BPBS_RST_SLAVE_CTRL;
		end else if (wrEn) begin
			if (hitPin | hitLatch) begin
				outputLatch <= pwdata[7:0];
			end
			if (hitDir) begin
				directionControl <= pwdata[7:0];
			end
			if (hitMem) begin
				memoryControl <= pwdata[7:0];
			end
			if (hitSlave) begin
				slaveControl <= pwdata[7:0];
			end
		end
	end

	// Read data mux; latch reads return the latch, not the pins.
	always @* begin
		next_prdata = 32'h0000_0000;
		if (hitPin) begin
			next_prdata = {24'h00_0000, pinIn};
		end else if (hitLatch) begin
			next_prdata = {24'h00_0000, outputLatch};
		end else if (hitDir) begin
			next_prdata = {24'h00_0000, directionControl};
		end else if (hitMem) begin
			next_prdata = {24'h00_0000, memoryControl};
		end else if (hitSlave) begin
			// Bit 7 reports a byte waiting from the outside processor.
			next_prdata = {24'h00_0000, slaveWriteFull, slaveControl[6:0]};
		end
	end

	// Read data is registered at setup so it stands during access.
	always @(posedge clk) begin
		if (reset) begin
			prdata <= 32'h0000_0000;
		end else if (psel & ~penable & ~pwrite) begin
			prdata <= next_prdata;
		end
	end

	// Slave port write capture and its full flag; a new byte beats a clear.
	always @(posedge clk) begin
		if (reset) begin
			slaveWriteData <= 8'h00;
			slaveWriteFull <= 1'b0;
		end else if (slaveCapture) begin
			slaveWriteData <= pinIn;
			slaveWriteFull <= 1'b1;
		end else if (access & ~pwrite & hitSlave) begin
			slaveWriteFull <= 1'b0;
		end
	end

	// Strobe decode for the slave port.
	bpbs_slave_ctrl uCtrl (
		.clk(clk),
		.reset(reset),
		.enable(slavePortActive),
		.readStrobe_n(slaveRead_n),
		.writeStrobe_n(slaveWrite_n),
		.chipSelect_n(slaveSelect_n),
		.readDrive(slaveReadDrive),
		.writeCapture(slaveCapture)
	);

	// One pin cell per pin; general port only when bus disabled.
	genvar i;
	generate
		for (i = 0; i < `BPBS_WIDTH; i = i + 1) begin : gPin
			bpbs_pin_cell uCell (
				.memBusActive(memBusActive),
				.slavePortActive(slavePortActive),
				.direction(directionControl[i]),
				.latchBit(outputLatch[i]),
				.memAdOut(lowAddrDataOut[i]),
				.memAdOe(lowAddrDataOe),
				.slaveReadOe(slaveReadDrive),
				.pinOut(pinOut[i]),
				.pinOe(pinOe[i])
			);
		end
	endgenerate
endmodule

/* pkg/bpbs_regs.vh */
/*
 * Register map and field constants for the shared bidirectional port.
 * Assumes a 32-bit APB slave with one aligned word per register.
 */
`ifndef BPBS_REGS_VH
`define BPBS_REGS_VH

// Byte offsets of the port registers.
`define BPBS_OFF_PIN_VALUE 12'h000
`define BPBS_OFF_OUTPUT_LATCH 12'h004
`define BPBS_OFF_DIRECTION 12'h008
`define BPBS_OFF_MEM_CTRL 12'h00C
`define BPBS_OFF_SLAVE_CTRL 12'h010

// Field positions inside the control registers.
`define BPBS_EXT_BUS_DISABLE_BIT 7
`define BPBS_SLAVE_PORT_MODE_BIT 4

// Reset values.
`define BPBS_RST_LATCH 8'h00
`define BPBS_RST_DIRECTION 8'hFF
`define BPBS_RST_MEM_CTRL 8'h80
`define BPBS_RST_SLAVE_CTRL 8'h00

// Pin count of the port.
`define BPBS_WIDTH 8

`endif

/* rtl/bpbs_pin_cell.v */
/*
 * One pin of the shared port: picks the owner of the pin driver.
 * Assumes the owner selects are mutually exclusive and prioritised above.
 */
`timescale 1ns/1ns
module bpbs_pin_cell (
	// Owner selects.
	input wire memBusActive,
	input wire slavePortActive,
	// Per-pin sources.
	input wire direction,
	input wire latchBit,
	input wire memAdOut,
	input wire memAdOe,
	input wire slaveReadOe,
	// Pin driver.
	output reg pinOut,
	output reg pinOe
);
	// Memory bus first, then slave port, then ordinary port.
	always @* begin
		if (memBusActive) begin
			pinOut = memAdOut;
			pinOe = memAdOe;
		end else if (slavePortActive) begin
			pinOut = latchBit;
			pinOe = slaveReadOe;
		end else begin
			pinOut = latchBit;
			pinOe = ~direction;
		end
	end
endmodule

/* rtl/bpbs_slave_ctrl.v */
/*
 * Control-strobe handling of the parallel slave port.
 * Assumes strobes arrive synchronous to clk and are active low.
 */
`timescale 1ns/1ns
module bpbs_slave_ctrl (
	// Clock and reset.
	input wire clk,
	input wire reset,
	// Mode enable.
	input wire enable,
	// Strobes from the neighbouring port.
	input wire readStrobe_n,
	input wire writeStrobe_n,
	input wire chipSelect_n,
	// Results.
	output wire readDrive,
	output reg writeCapture
);
	// Previous write-active level, for the trailing-edge capture.
	reg writeActive;
	wire next_writeActive;

	// Strobes only count in slave mode; the pins are inputs then except during a selected read.
	assign next_writeActive = enable & ~chipSelect_n & ~writeStrobe_n;
	assign readDrive = enable & ~chipSelect_n & ~readStrobe_n;

	// Capture the pin byte as the write strobe ends.
	always @(posedge clk) begin
		if (reset) begin
			writeActive <= 1'b0;
			writeCapture <= 1'b0;
		end else begin
			writeActive <= next_writeActive;
			writeCapture <= writeActive & ~next_writeActive;
		end
	end
endmodule

/* test/bpbs_board.sv */
/* Board beside the port: resolves each pin level.
   Assumes a strong board source wherever the port's driver is off. */
`timescale 1ns/1ns
module bpbs_board (
	// Port driver.
	input wire [7:0] pinOut,
	input wire [7:0] pinOe,
	// Board source and resolved pins.
	input wire [7:0] boardVal,
	output wire [7:0] pinIn
);
	// A driven pin shows the port's value, others the board's.
	assign pinIn = (pinOut & pinOe) | (boardVal & ~pinOe);
endmodule

/* test/bpbs_port_sva.sv */
/* Checker on the port's pins and APB side.
   Assumes one clock domain with synchronous active-high reset. */
`timescale 1ns/1ns
module bpbs_port_sva (
	input wire clk, input wire reset,
	input wire psel, input wire penable, input wire pwrite,
	input wire [11:0] paddr, input wire pready, input wire pslverr,
	input wire [31:0] prdata, input wire [7:0] pinIn,
	input wire [7:0] pinOe, input wire [7:0] lowAddrDataIn,
	input wire slaveRead_n, input wire slaveSelect_n,
	input wire [7:0] slaveWriteData, input wire slaveWriteFull,
	input wire slavePortActive
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// Access phase of any APB transfer.
	sequence s_acc; psel && penable; endsequence
	// A slave read strobe pair while the slave port owns the pins.
	sequence s_srd; slavePortActive && !slaveSelect_n && !slaveRead_n;
	endsequence
	property p_ready; s_acc |-> pready; endproperty
	property p_err; s_acc ##0 (paddr > 12'h010) |-> pslverr; endproperty
	property p_ok; s_acc ##0 (paddr == 12'h008) |-> !pslverr; endproperty
	property p_zero;
		s_acc ##0 (!pwrite && paddr == 12'h014) |-> prdata == 32'h0000_0000;
	endproperty
	property p_rst; $fell(reset) |-> pinOe == 8'h00; endproperty
	property p_srd; s_srd |-> pinOe == 8'hFF; endproperty
	property p_cap;
		$rose(slaveWriteFull) |-> slaveWriteData == $past(pinIn);
	endproperty
	property p_mem; lowAddrDataIn == pinIn; endproperty
	a_ready: assert property (p_ready) else $error("pready low");
	a_err: assert property (p_err) else $error("no pslverr");
	a_ok: assert property (p_ok) else $error("false pslverr");
	a_zero: assert property (p_zero) else $error("unmapped data");
	a_rst: assert property (p_rst) else $error("drives after reset");
	a_srd: assert property (p_srd) else $error("slave read off");
	a_cap: assert property (p_cap) else $error("bad capture");
	a_mem: assert property (p_mem) else $error("bus input");
endmodule
bind bpbs_port bpbs_port_sva chk (.clk, .reset, .psel, .penable, .pwrite,
	.paddr, .pready, .pslverr, .prdata, .pinIn, .pinOe, .lowAddrDataIn,
	.slaveRead_n, .slaveSelect_n, .slaveWriteData, .slaveWriteFull,
	.slavePortActive);

/* test/testbench.sv */
/* Register-level test of the shared port through APB calls.
   Assumes the board model resolves the pins. */
`timescale 1ns/1ns
module testbench;
	reg clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
	reg [11:0] paddr = 0; reg [31:0] pwdata = 0, q;
	reg [7:0] mOut = 0, bVal = 8'hA5; reg mOe = 0, rdN = 1, wrN = 1, csN = 1;
	wire pready, pslverr, full, act; wire [31:0] prdata;
	wire [7:0] pinIn, pinOut, pinOe, adIn, sData;
	integer errors = 0, n_tests = 0, k;
	always #5 clk = ~clk;
	bpbs_port uut (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.pslverr(pslverr), .prdata(prdata), .pinIn(pinIn), .pinOut(pinOut),
		.pinOe(pinOe), .lowAddrDataOut(mOut), .lowAddrDataOe(mOe),
		.lowAddrDataIn(adIn), .slaveRead_n(rdN), .slaveWrite_n(wrN),
		.slaveSelect_n(csN), .slaveWriteData(sData), .slaveWriteFull(full),
		.slavePortActive(act));
	bpbs_board brd (.pinOut(pinOut), .pinOe(pinOe), .boardVal(bVal),
		.pinIn(pinIn));
	// Prints the counts and the verdict, then stops.
	task conclude; begin
		$display("tests %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	end endtask
	// Compares once outputs settle.
	task chk(input [31:0] got, input [31:0] exp); begin
		#1 n_tests = n_tests + 1;
		if (got !== exp) begin
			errors = errors + 1;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	end endtask
	// One APB transfer, held until pready is seen high.
	task xfer(input w, input [11:0] a, input [31:0] d); begin
		@(posedge clk); psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clk); penable <= 1;
		@(posedge clk); k = 0;
		while (pready !== 1'b1 && k < 20) begin @(posedge clk); k = k + 1; end
		if (k == 20) begin errors = errors + 1; conclude; end
		q = prdata; psel <= 0; penable <= 0;
		// Let the write's register update settle before anyone compares.
		#1;
	end endtask
	initial begin
		repeat (4) @(posedge clk); reset <= 0;
		xfer(0, 12'h004, 0); chk(q, 32'h0000_0000);
		xfer(0, 12'h008, 0); chk(q, 32'h0000_00FF);
		xfer(0, 12'h00C, 0); chk(q, 32'h0000_0080);
		xfer(1, 12'h008, 32'h0000_00CF); xfer(1, 12'h004, 32'h0000_005A);
		chk(pinOe, 8'h30); chk(pinOut & pinOe, 8'h10);
		xfer(0, 12'h000, 0); chk(q, 32'h0000_0095);
		xfer(0, 12'h004, 0); chk(q, 32'h0000_005A);
		xfer(1, 12'h000, 32'h0000_003C); xfer(0, 12'h004, 0);
		chk(q, 32'h0000_003C);
		xfer(0, 12'h014, 0); chk(q, 32'h0000_0000);
		// Memory bus takes the pins, even over slave mode.
		mOut <= 8'h77; mOe <= 1; xfer(1, 12'h010, 32'h0000_0010);
		xfer(1, 12'h00C, 0); chk(pinOe, 8'hFF);
		chk(pinOut, 8'h77); chk(act, 1'b0);
		chk(adIn, 8'h77);
		xfer(1, 12'h00C, 32'h0000_0080); chk(act, 1'b1);
		@(posedge clk); csN <= 0; rdN <= 0; #1;
		chk(pinOe, 8'hFF);
		chk(pinOut, 8'h3C);
		@(posedge clk); rdN <= 1; bVal <= 8'hC3; wrN <= 0;
		@(posedge clk); wrN <= 1; csN <= 1; repeat (3) @(posedge clk);
		chk(sData, 8'hC3); chk(full, 1'b1);
		xfer(0, 12'h010, 0); chk(q, 32'h0000_0090);
		xfer(0, 12'h010, 0); chk(q, 32'h0000_0010);
		conclude;
	end
endmodule
